// ==== hdl/vpic_pkg.sv ====
// Constants and state types shared by both ends of the vectored controller.
// Assumes 32-bit registers at byte addresses on the link and on the software bus.
package vpic_pkg;

	// ----------------------------------------------------------------
	// Device map on the link
	// ----------------------------------------------------------------
	localparam logic [31:0] VPIC_SMR_BASE = 32'hfffff000;
	localparam logic [31:0] VPIC_SVR_BASE = 32'hfffff080;
	localparam logic [31:0] VPIC_IVR_ADDR = 32'hfffff100;
	localparam logic [31:0] VPIC_CUR_ADDR = 32'hfffff108;
	localparam logic [31:0] VPIC_CLR_ADDR = 32'hfffff128;
	localparam logic [31:0] VPIC_EOI_ADDR = 32'hfffff130;
	localparam logic [31:0] VPIC_SPU_ADDR = 32'hfffff134;
	localparam logic [31:0] VPIC_BLK_MASK = 32'hffffff80;
	localparam int VPIC_PRIO_LSB = 0;
	localparam int VPIC_TRIG_BIT = 5;
	localparam logic [3:0] VPIC_STACK_DEPTH = 4'h8;
	localparam logic [31:0] VPIC_SPU_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Host software registers (APB byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] VPIC_H_ADDR = 8'h00;
	localparam logic [7:0] VPIC_H_WDATA = 8'h04;
	localparam logic [7:0] VPIC_H_CMD = 8'h08;
	localparam logic [7:0] VPIC_H_STAT = 8'h0c;
	localparam logic [7:0] VPIC_H_RDATA = 8'h10;
	localparam logic [7:0] VPIC_H_CTRL = 8'h14;
	localparam logic [1:0] VPIC_OP_READ = 2'h0;
	localparam logic [1:0] VPIC_OP_WRITE = 2'h1;
	localparam logic [1:0] VPIC_OP_TAKE = 2'h2;
	localparam logic [1:0] VPIC_OP_END = 2'h3;

	typedef enum logic [0:0] {VPIC_IDLE = 1'b0, VPIC_WAIT = 1'b1} vpic_hst_e;

	typedef struct packed {
		logic [31:0] pend;
		logic [31:0] prev;
		logic [31:0] edge_md;
		logic [31:0][2:0] prio;
		logic [31:0][31:0] vec;
		logic [31:0] spur;
		logic [7:0][4:0] stk_src;
		logic [7:0][2:0] stk_lvl;
		logic [3:0] depth;
		logic ack;
		logic [31:0] rdata;
		logic normal_irq_request_n_n;
		logic fast_irq_request_n_n;
		logic [4:0] cur;
		logic busy;
	} vpic_dev_s;

	typedef struct packed {
		vpic_hst_e st;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0] op;
		logic irq_mask;
		logic req;
		logic we;
		logic pready;
		logic [31:0] prdata;
		logic irq;
		logic fiq;
	} vpic_hst_s;

	// Address falls in a 32-word block starting at base
	function automatic logic vpic_in_blk(input logic [31:0] a,
		input logic [31:0] base);
		return ((a & VPIC_BLK_MASK) == base) && (a[1:0] == 2'b00);
	endfunction

endpackage

// ==== hdl/vpic_link_if.sv ====
// Link between the processor-side end and the interrupt controller.
// Assumes both ends share pclk; req is held until ack is seen.
`timescale 1ns/1ns
interface vpic_link_if;
	logic req;
	logic we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic ack;
	logic [31:0] rdata;
	logic normal_irq_request_n;
	logic fast_irq_request_n;

	modport dev (input req, input we, input addr, input wdata,
		output ack, output rdata, output normal_irq_request_n,
		output fast_irq_request_n);
	modport host (output req, output we, output addr, output wdata,
		input ack, input rdata, input normal_irq_request_n,
		input fast_irq_request_n);
endinterface

// ==== hdl/vpic_resolve.sv ====
// Priority resolver over sources 1 to 31, purely combinational.
// Assumes act already excludes disabled and fast-forced sources.
`timescale 1ns/1ns
module vpic_resolve (
	// Candidates
	input wire logic [31:0] act,
	input wire logic [31:0][2:0] prio,
	// Winner
	output logic found,
	output logic [4:0] src,
	output logic [2:0] lvl
);
	always_comb begin
		found = 1'b0;
		src = 5'h00;
		lvl = 3'h0;
		// Downward scan with >= leaves the lowest number on ties
		for (int i = 31; i >= 1; i--) begin
			if (act[i] && (!found || prio[i] >= lvl)) begin
				found = 1'b1;
				src = 5'(i);
				lvl = prio[i];
			end
		end
	end
endmodule // vpic_resolve

// ==== hdl/vpic_dev.sv ====
// Normal-interrupt controller end: resolver, level stack, vectors.
// Assumes src_in, src_enabled, src_fast_force synchronous to pclk.
//
// Chosen here: the req/ack link interface to the registers.
`timescale 1ns/1ns
module vpic_dev (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Source side
	input wire logic [31:0] src_in,
	input wire logic [31:0] src_enabled,
	input wire logic [31:0] src_fast_force,
	// Status
	output logic [4:0] cur_src,
	output logic in_service,
	// Link
	vpic_link_if.dev link
);
	vpic_pkg::vpic_dev_s q;
	vpic_pkg::vpic_dev_s d;
	logic [31:0] act;
	logic found;
	logic [4:0] win_src;
	logic [2:0] win_lvl;
	logic [2:0] top_lvl;
	logic [2:0] top_idx;
	logic higher;

	// ----------------------------------------------------------------
	// Candidate set and resolution
	// ----------------------------------------------------------------
	assign top_idx = q.depth[2:0] - 3'h1;
	assign top_lvl = q.stk_lvl[top_idx];

	always_comb begin
		// Normal path excludes source 0 and forced sources
		act = src_enabled & ~src_fast_force &
			((q.edge_md & q.pend) | (~q.edge_md & src_in));
		act[0] = 1'b0;
	end

	vpic_resolve u_resolve (
		.act(act),
		.prio(q.prio),
		.found(found),
		.src(win_src),
		.lvl(win_lvl)
	);

	// Only strictly above the current level may interrupt
	assign higher = found && (q.depth == 4'h0 || win_lvl > top_lvl);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic taken;
		logic rd;
		logic wr;
		logic [31:0] rise;
		logic [31:0] clr;
		logic [4:0] idx;
		logic ivr_rd;
		logic fast;
		logic [2:0] nidx;
		taken = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		rise = 32'h00000000;
		clr = 32'h00000000;
		idx = 5'h00;
		ivr_rd = 1'b0;
		fast = 1'b0;
		nidx = 3'h0;
		d = q;
		taken = link.req && !q.ack;
		rd = taken && !link.we;
		wr = taken && link.we;
		idx = link.addr[6:2];
		rise = src_in & ~q.prev;
		d.prev = src_in;
		d.ack = taken;
		d.rdata = 32'h00000000;
		// Register decode
		if (vpic_pkg::vpic_in_blk(link.addr, vpic_pkg::VPIC_SMR_BASE)) begin
			if (wr) begin
				// Priority field of the source mode setting
				d.prio[idx] = link.wdata[vpic_pkg::VPIC_PRIO_LSB +: 3];
				d.edge_md[idx] = link.wdata[vpic_pkg::VPIC_TRIG_BIT];
			end
			d.rdata[vpic_pkg::VPIC_PRIO_LSB +: 3] = q.prio[idx];
			d.rdata[vpic_pkg::VPIC_TRIG_BIT] = q.edge_md[idx];
		end else if (vpic_pkg::vpic_in_blk(link.addr,
			vpic_pkg::VPIC_SVR_BASE)) begin
			if (wr) begin
				d.vec[idx] = link.wdata;
			end
			d.rdata = q.vec[idx];
		end else if (link.addr == vpic_pkg::VPIC_IVR_ADDR) begin
			// Vector register at its fixed address
			ivr_rd = rd;
			if (higher) begin
				// Handler word of the new current source
				d.rdata = q.vec[win_src];
			end else begin
				d.rdata = q.spur;
			end
		end else if (link.addr == vpic_pkg::VPIC_CUR_ADDR) begin
			d.rdata = {27'h0000000, (q.depth != 4'h0) ?
				q.stk_src[top_idx] : 5'h00};
		end else if (link.addr == vpic_pkg::VPIC_CLR_ADDR) begin
			if (wr) begin
				clr = link.wdata;
			end
		end else if (link.addr == vpic_pkg::VPIC_EOI_ADDR) begin
			// Pop restores the previous level, or none
			if (wr && q.depth != 4'h0) begin
				d.depth = q.depth - 4'h1;
			end
		end else if (link.addr == vpic_pkg::VPIC_SPU_ADDR) begin
			if (wr) begin
				d.spur = link.wdata;
			end
			d.rdata = q.spur;
		end
		// Writes answer with zero data
		if (!rd) begin
			d.rdata = 32'h00000000;
		end
		// Current source chosen at the moment of the read
		if (ivr_rd && higher) begin
			// Push while room remains in the stack
			if (q.depth != vpic_pkg::VPIC_STACK_DEPTH) begin
				d.stk_src[q.depth[2:0]] = win_src;
				d.stk_lvl[q.depth[2:0]] = win_lvl;
				d.depth = q.depth + 4'h1;
			end
			// Auto-clear edge source; forced never in act
			if (q.edge_md[win_src] && !src_fast_force[win_src]) begin
				clr[win_src] = 1'b1;
			end
		end
		// A new edge in the clearing cycle survives the clear
		d.pend = ((q.pend & ~clr) | rise) & q.edge_md;
		// Status outputs come from flops, not the stack mux
		nidx = d.depth[2:0] - 3'h1;
		d.busy = (d.depth != 4'h0);
		d.cur = d.busy ? d.stk_src[nidx] : 5'h00;
		// Request tracks the stack top every cycle
		// Forced high on the read; re-evaluated next cycle
		d.normal_irq_request_n_n = !higher || ivr_rd;
		// Fast: source 0 plus forced sources
		fast = src_enabled[0] &&
			(q.edge_md[0] ? q.pend[0] : src_in[0]);
		for (int i = 1; i < 32; i++) begin
			if (act[i] == 1'b0 && src_enabled[i] && src_fast_force[i] &&
				(q.edge_md[i] ? q.pend[i] : src_in[i])) begin
				fast = 1'b1;
			end
		end
		d.fast_irq_request_n_n = !fast;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Empty stack and idle request lines out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.spur <= vpic_pkg::VPIC_SPU_RESET;
			q.normal_irq_request_n_n <= 1'b1;
			q.fast_irq_request_n_n <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.ack = q.ack;
	assign link.rdata = q.rdata;
	assign link.normal_irq_request_n = q.normal_irq_request_n_n;
	assign link.fast_irq_request_n = q.fast_irq_request_n_n;
	assign cur_src = q.cur;
	assign in_service = q.busy;

endmodule // vpic_dev

// ==== hdl/vpic_host.sv ====
// Processor-side end: APB registers turn software orders into link
// transfers and report request lines. Assumes one pclk domain.
`timescale 1ns/1ns
module vpic_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Core request lines
	output logic irq,
	output logic fiq,
	// Link
	vpic_link_if.host link
);
	vpic_pkg::vpic_hst_s q;
	vpic_pkg::vpic_hst_s d;

	always_comb begin
		logic acc;
		logic wr;
		logic busy;
		acc = 1'b0;
		wr = 1'b0;
		busy = 1'b0;
		d = q;
		busy = (q.st == vpic_pkg::VPIC_WAIT);
		// One wait state so prdata comes from a flop
		acc = psel && penable && !q.pready;
		wr = psel && penable && q.pready && pwrite;
		d.pready = acc;
		if (acc) begin
			if (paddr == vpic_pkg::VPIC_H_ADDR) begin
				d.prdata = q.addr;
			end else if (paddr == vpic_pkg::VPIC_H_WDATA) begin
				d.prdata = q.wdata;
			end else if (paddr == vpic_pkg::VPIC_H_STAT) begin
				d.prdata = {29'h00000000, !link.fast_irq_request_n,
					!link.normal_irq_request_n, busy};
			end else if (paddr == vpic_pkg::VPIC_H_RDATA) begin
				d.prdata = q.rdata;
			end else if (paddr == vpic_pkg::VPIC_H_CTRL) begin
				d.prdata = {31'h00000000, q.irq_mask};
			end else begin
				d.prdata = 32'h00000000;
			end
		end
		// Ack handling first, so a new command can raise req
		case (q.st)
			vpic_pkg::VPIC_WAIT: begin
				if (link.ack) begin
					d.req = 1'b0;
					d.st = vpic_pkg::VPIC_IDLE;
					if (!q.we) begin
						d.rdata = link.rdata;
					end
				end
			end
			default: begin
				d.req = 1'b0;
			end
		endcase
		if (wr) begin
			if (paddr == vpic_pkg::VPIC_H_ADDR) begin
				d.addr = pwdata;
			end else if (paddr == vpic_pkg::VPIC_H_WDATA) begin
				d.wdata = pwdata;
			end else if (paddr == vpic_pkg::VPIC_H_CTRL) begin
				d.irq_mask = pwdata[0];
			end else if (paddr == vpic_pkg::VPIC_H_CMD && !busy) begin
				// Orders while busy are dropped
				d.st = vpic_pkg::VPIC_WAIT;
				d.op = pwdata[1:0];
				d.req = 1'b1;
				case (pwdata[1:0])
					vpic_pkg::VPIC_OP_READ: begin
						d.we = 1'b0;
					end
					vpic_pkg::VPIC_OP_WRITE: begin
						d.we = 1'b1;
					end
					// Entry read of the vector register
					vpic_pkg::VPIC_OP_TAKE: begin
						d.we = 1'b0;
						d.addr = vpic_pkg::VPIC_IVR_ADDR;
					end
					default: begin
						d.we = 1'b1;
						d.addr = vpic_pkg::VPIC_EOI_ADDR;
					end
				endcase
			end
		end
		// Core mask gates the normal request
		d.irq = !link.normal_irq_request_n && !q.irq_mask;
		d.fiq = !link.fast_irq_request_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= vpic_pkg::VPIC_IDLE;
		end else if (ce) begin
			q <= d;
		end
	end

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = 1'b0;
	assign irq = q.irq;
	assign fiq = q.fiq;
	assign link.req = q.req;
	assign link.we = q.we;
	assign link.addr = q.addr;
	assign link.wdata = q.wdata;

endmodule // vpic_host

// ==== verification/vpic_link_monitor.sv ====
// Protocol checks on the link joining the two controller ends.
// Assumes one pclk domain; instantiated beside the link interface.
`timescale 1ns/1ns
module vpic_link_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic req,
	input wire logic we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata,
	input wire logic normal_irq_request_n,
	input wire logic fast_irq_request_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_ack_next;
		req && !ack |=> ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		ack |=> !ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
	property p_ack_cause;
		!req |=> !ack;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_req_drop;
		ack |=> !req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("req kept");
	property p_req_hold;
		req && !ack |=> req && $stable(addr) && $stable(we);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("req moved");
	property p_wd_hold;
		req && we && !ack |=> $stable(wdata);
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("wdata moved");
	property p_wr_zero;
		ack && we |-> rdata == 32'h00000000;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write data back");
	// Vector read takes the request away
	property p_ivr_drop;
		ack && !we && addr == vpic_pkg::VPIC_IVR_ADDR
			|-> ##[0:1] normal_irq_request_n;
	endproperty
	a_ivr_drop: assert property (p_ivr_drop) else $error("req not dropped");
endmodule // vpic_link_monitor

// ==== verification/tb_vectored_priority_irq_controller.sv ====
// Bench joining both controller ends; software side over APB.
// Assumes ce held high; sources driven at pclk edges.
`timescale 1ns/1ns
module tb_vectored_priority_irq_controller;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] src_in = 32'h00000000;
	logic [31:0] src_enabled = 32'hfffffffe;
	logic [31:0] src_fast_force = 32'h00000000;
	wire logic pready;
	wire logic pslverr;
	wire logic irq;
	wire logic fiq;
	wire logic [31:0] prdata;
	wire logic [4:0] cur_src;
	wire logic in_service;
	int failures = 0;
	int total_checks = 0;
	logic [31:0] r;

	always #2 pclk = ~pclk;

	vpic_link_if link ();
	vpic_dev u_vpic_dev (.pclk(pclk), .presetn(presetn), .ce(ce),
		.src_in(src_in), .src_enabled(src_enabled),
		.src_fast_force(src_fast_force), .cur_src(cur_src),
		.in_service(in_service), .link(link));
	vpic_host u_vpic_host (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .irq(irq), .fiq(fiq), .link(link));
	vpic_link_monitor u_mon (.pclk(pclk), .presetn(presetn),
		.req(link.req), .we(link.we), .addr(link.addr),
		.wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
		.normal_irq_request_n(link.normal_irq_request_n),
		.fast_irq_request_n(link.fast_irq_request_n));

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// Starts just after an edge, ends one idle edge later
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// One link order through the host registers, result in q
	task automatic op(input logic [1:0] c, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		apb(1'b1, vpic_pkg::VPIC_H_ADDR, a, q);
		apb(1'b1, vpic_pkg::VPIC_H_WDATA, d, q);
		apb(1'b1, vpic_pkg::VPIC_H_CMD, {30'h0, c}, q);
		do begin
			apb(1'b0, vpic_pkg::VPIC_H_STAT, 32'h0, q);
		end while (q[0] !== 1'b0);
		apb(1'b0, vpic_pkg::VPIC_H_RDATA, 32'h0, q);
	endtask

	task automatic cfg(input int s, input logic [31:0] mode);
		logic [31:0] q;
		op(vpic_pkg::VPIC_OP_WRITE, vpic_pkg::VPIC_SMR_BASE + 4 * s,
			mode, q);
		op(vpic_pkg::VPIC_OP_WRITE, vpic_pkg::VPIC_SVR_BASE + 4 * s,
			32'h100 + s, q);
	endtask

	task automatic take(output logic [31:0] q);
		op(vpic_pkg::VPIC_OP_TAKE, 32'h0, 32'h0, q);
	endtask

	task automatic eoi();
		logic [31:0] q;
		op(vpic_pkg::VPIC_OP_END, 32'h0, 32'h0, q);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		// Idle after reset
		chk("irq", 32'h0, 32'(irq));
		chk("cur", 32'h0, 32'(cur_src));
		chk("busy", 32'h0, 32'(in_service));
		op(vpic_pkg::VPIC_OP_READ, vpic_pkg::VPIC_SPU_ADDR, 32'h0, r);
		chk("spur", vpic_pkg::VPIC_SPU_RESET, r);
		op(vpic_pkg::VPIC_OP_READ, 32'hfffff1f0, 32'h0, r);
		chk("unmapped", 32'h0, r);
		$display("test reset done");
	endtask

	// Ties, lower levels held back, re-request after pop
	task automatic t_tie();
		int s[3] = '{2, 3, 7};
		cfg(2, 32'h5);
		cfg(3, 32'h5);
		cfg(7, 32'h2);
		op(vpic_pkg::VPIC_OP_READ, vpic_pkg::VPIC_SMR_BASE + 32'h8,
			32'h0, r);
		chk("mode", 32'h5, r);
		src_in <= 32'h0000008c;
		tick(4);
		for (int i = 0; i < 3; i++) begin
			chk("irq", 32'h1, 32'(irq));
			take(r);
			chk("vec", 32'h100 + s[i], r);
			chk("cur", s[i], 32'(cur_src));
			tick(4);
			chk("irq", 32'h0, 32'(irq));
			src_in[s[i]] <= 1'b0;
			// Core masked across the end command
			apb(1'b1, vpic_pkg::VPIC_H_CTRL, 32'h1, r);
			eoi();
			tick(4);
			chk("masked", 32'h0, 32'(irq));
			apb(1'b1, vpic_pkg::VPIC_H_CTRL, 32'h0, r);
			tick(2);
		end
		chk("busy", 32'h0, 32'(in_service));
		$display("test tie done");
	endtask

	// Eight nested edge sources, full stack, unwind, spurious read
	task automatic t_nest();
		for (int k = 0; k < 8; k++)
			cfg(10 + k, (32'h1 << vpic_pkg::VPIC_TRIG_BIT) | k);
		op(vpic_pkg::VPIC_OP_WRITE, vpic_pkg::VPIC_SPU_ADDR, 32'h5a5a, r);
		for (int k = 0; k < 8; k++) begin
			src_in[10 + k] <= 1'b1;
			tick(1);
			src_in[10 + k] <= 1'b0;
			tick(4);
			chk("irq", 32'h1, 32'(irq));
			take(r);
			chk("vec", 32'h10a + k, r);
			chk("cur", 10 + k, 32'(cur_src));
		end
		op(vpic_pkg::VPIC_OP_READ, vpic_pkg::VPIC_CUR_ADDR, 32'h0, r);
		chk("cur reg", 32'h11, r);
		for (int k = 7; k >= 0; k--) begin
			chk("cur", 10 + k, 32'(cur_src));
			eoi();
		end
		chk("busy", 32'h0, 32'(in_service));
		take(r);
		chk("vec", 32'h5a5a, r);
		chk("busy", 32'h0, 32'(in_service));
		$display("test nest done");
	endtask

	// Fast path from source 0 and from a forced source
	task automatic t_fast();
		src_enabled <= 32'hffffffff;
		src_in <= 32'h1;
		tick(4);
		chk("fiq", 32'h1, 32'(fiq));
		chk("irq", 32'h0, 32'(irq));
		src_in <= 32'h0;
		tick(4);
		chk("fiq", 32'h0, 32'(fiq));
		// Edge mode, so the vector read could clear it if wrong
		cfg(4, (32'h1 << vpic_pkg::VPIC_TRIG_BIT) | 32'h7);
		src_fast_force <= 32'h10;
		src_in <= 32'h10;
		tick(4);
		chk("fiq", 32'h1, 32'(fiq));
		chk("irq", 32'h0, 32'(irq));
		take(r);
		chk("vec", 32'h5a5a, r);
		tick(2);
		chk("fiq", 32'h1, 32'(fiq));
		op(vpic_pkg::VPIC_OP_WRITE, vpic_pkg::VPIC_CLR_ADDR, 32'h10,
			r);
		tick(4);
		chk("fiq", 32'h0, 32'(fiq));
		src_in <= 32'h0;
		src_fast_force <= 32'h0;
		$display("test fast done");
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_tie();
		t_nest();
		t_fast();
		give_verdict();
	end

	// Whole run needs about 1200 cycles
	initial begin
		repeat (30000) @(posedge pclk);
		failures++;
		give_verdict();
	end
endmodule // tb_vectored_priority_irq_controller
